// ==== rtl/qdr_cfg.svh ====
// constants of the quad converter readback slave: offsets, fields, reset values
// assumes inclusion by bare name from every design file that needs them
`ifndef QDR_CFG_SVH
`define QDR_CFG_SVH

`define QDR_OFF_CHAN0       5'h00
`define QDR_OFF_CHAN3       5'h0c
`define QDR_OFF_STATUS      5'h10
`define QDR_CHAN_RESET      14'h0000
`define QDR_ADDR_PREFIX     5'h13
`define QDR_BITS_PER_BYTE   4'h8
`define QDR_LAST_BIT        3'h7
`define QDR_BYTES_SHORT     2'h2
`define QDR_BYTES_LONG      2'h3
`define QDR_PROD_IDLE       2'h3
`define QDR_PD_FILL         6'h3f
`define QDR_LOW_FILL        4'h0
`define QDR_IDLE_BYTE       8'hff
`define QDR_CTRL_FMT_BIT    0
`define QDR_CTRL_SEL_LSB    1
`define QDR_STAT_ACTIVE_BIT 8

`endif

// ==== rtl/qdr_pkg.sv ====
// types shared by the readback slave
// assumes nothing beyond a SystemVerilog compiler
package qdr_pkg;
   typedef enum logic [3:0] {
      QDR_IDLE, QDR_ADDR, QDR_ACK_ADDR, QDR_CTRL, QDR_ACK_CTRL,
      QDR_WAIT, QDR_TX, QDR_MACK, QDR_DONE
   } qdr_state_t;
   typedef enum logic [1:0] {
      QDR_KIND_PD, QDR_KIND_HI, QDR_KIND_LO, QDR_KIND_NONE
   } qdr_kind_t;
endpackage

// ==== rtl/qdr_sync.sv ====
// two-flop synchroniser, one per bit
// assumes its inputs come from outside the clk domain
`timescale 1ns/100ps
`default_nettype none
module qdr_sync #(
   parameter int WIDTH = 4
) (
   input  wire logic             clk,   // system clock
   input  wire logic             rst,   // async reset, high
   input  wire logic             ce,    // clock enable
   input  wire logic [WIDTH-1:0] d,     // asynchronous inputs
   output var  logic [WIDTH-1:0] q      // synchronised outputs
);
   genvar g;
   for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_reg;
      // meta_reg is read by the second flop only
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            meta_reg <= 1'b1;
            q[g]     <= 1'b1;
         end else if (ce) begin
            meta_reg <= d[g];
            q[g]     <= meta_reg;
         end
      end
   end
endmodule
`default_nettype wire

// ==== rtl/qdr_fifo2.sv ====
// small flop buffer with valid/ready on both sides and a flush
// assumes producer and consumer share clk
`timescale 1ns/100ps
`default_nettype none
module qdr_fifo2 #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input  wire logic             clk,       // system clock
   input  wire logic             rst,       // async reset, high
   input  wire logic             ce,        // clock enable
   input  wire logic             flush,     // drop all entries
   input  wire logic             in_valid,  // producer has a word
   output logic                  in_ready,  // room for a word
   input  wire logic [WIDTH-1:0] in_data,   // word in
   output logic                  out_valid, // word available
   input  wire logic             out_ready, // consumer takes the word
   output logic      [WIDTH-1:0] out_data   // word out
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   wire              do_push = in_valid && in_ready;
   wire              do_pop  = out_valid && out_ready;
   wire  [AW-1:0]    wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
   wire  [AW-1:0]    rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;

   assign in_ready  = (count_reg != (AW + 1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign out_data  = mem_reg[rd_ptr_reg];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else if (ce) begin
         if (flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
         end else begin
            if (do_push) wr_ptr_reg <= wr_ptr_next;
            if (do_pop) rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_reg + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
         end
      end
   end

   // storage has no reset; entries are only read after being written
   always_ff @(posedge clk) begin
      if (ce && do_push && !flush) mem_reg[wr_ptr_reg] <= in_data;
   end
endmodule
`default_nettype wire

// ==== rtl/qdr_readback.sv ====
// i2c slave-transmitter readback path of a quad channel converter
// assumes scl and sda arrive asynchronously and that scl is far slower than clk_sys
// Contract
// - acknowledge own address by pulling sda
// - control byte received and acknowledged
// - ack read address, then transmit data
// - channel select bits pick returned channel
// - format zero returns high, then low
// - format one prepends power-down byte
// - high byte holds data bits 11..4
// - low byte holds data bits 3..0 high
// - power-down byte: code bits, six ones
// - channel registers fourteen bits wide
// - reset clears every channel register
`include "qdr_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module qdr_readback (
   input  wire logic        CLK_SYS,     // system clock, 50 MHz
   input  wire logic        RST,         // async reset, high
   input  wire logic        CE,          // clock enable, freezes all state when low
   input  wire logic        SCL_I,       // i2c clock pin level
   input  wire logic        SDA_I,       // i2c data pin level
   output logic             SDA_O,       // i2c data drive value, always low
   output logic             SDA_OE,      // high while pulling sda low
   input  wire logic        ADDR_PIN_HI, // upper address strap
   input  wire logic        ADDR_PIN_LO, // lower address strap
   input  wire logic [4:0]  REG_ADDR,    // register byte address
   input  wire logic [31:0] REG_WDATA,   // register write data
   input  wire logic        REG_WR,      // write strobe
   input  wire logic        REG_RD,      // read strobe
   output logic      [31:0] REG_RDATA    // read data, cycle after strobe
);
   logic [3:0]          pins_s;
   logic                scl_s, sda_s, addr_hi_s, addr_lo_s;
   logic                scl_d_reg, sda_d_reg;
   qdr_pkg::qdr_state_t state_reg, state_next;
   logic [3:0]          bit_cnt_reg, bit_cnt_next;
   logic [7:0]          rx_shift_reg, rx_shift_next;
   logic [7:0]          ctrl_reg, ctrl_next;
   logic [7:0]          tx_shift_reg, tx_shift_next;
   logic [1:0]          tx_cnt_reg, tx_cnt_next;
   logic                ack_reg, ack_next;
   logic                sda_oe_reg, sda_oe_next;
   logic [13:0]         snap_reg;
   logic [1:0]          prod_idx_reg;
   logic [13:0]         chan_reg [4];
   logic [31:0]         rdata_reg;
   logic                fifo_flush, fifo_pop, load_snap;
   logic                fifo_in_ready, fifo_out_valid;
   logic [7:0]          fifo_out_data;

   qdr_sync #(.WIDTH(4)) u_sync (
      .clk (CLK_SYS),
      .rst (RST),
      .ce  (CE),
      .d   ({SCL_I, SDA_I, ADDR_PIN_HI, ADDR_PIN_LO}),
      .q   (pins_s)
   );
   assign {scl_s, sda_s, addr_hi_s, addr_lo_s} = pins_s;

   // line events, from synchronised levels only
   wire scl_rise  = scl_s && !scl_d_reg;
   wire scl_fall  = !scl_s && scl_d_reg;
   wire start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
   wire stop_det  = scl_s && scl_d_reg && !sda_d_reg && sda_s;
   wire byte_full = (bit_cnt_reg == `QDR_BITS_PER_BYTE);
   wire addr_match = (rx_shift_reg[7:1] == {`QDR_ADDR_PREFIX, addr_hi_s, addr_lo_s});
   wire rw_read    = rx_shift_reg[0];
   wire fmt_long   = ctrl_reg[`QDR_CTRL_FMT_BIT];
   wire [1:0] chan_sel   = ctrl_reg[`QDR_CTRL_SEL_LSB +: 2];
   wire [1:0] byte_total = fmt_long ? `QDR_BYTES_LONG : `QDR_BYTES_SHORT;
   wire [13:0] chan_mux  = chan_reg[chan_sel];

   // byte producer: fills the buffer from the channel snapshot
   wire [1:0] kind_idx  = prod_idx_reg + (fmt_long ? 2'h0 : 2'h1);
   qdr_pkg::qdr_kind_t push_kind;
   assign push_kind = qdr_pkg::qdr_kind_t'(kind_idx);
   wire       push_valid = (prod_idx_reg < byte_total) && !load_snap;
   wire [7:0] pd_byte = {snap_reg[13:12], `QDR_PD_FILL};
   wire [7:0] hi_byte = snap_reg[11:4];
   wire [7:0] lo_byte = {snap_reg[3:0], `QDR_LOW_FILL};
   wire [7:0] push_data = (push_kind == qdr_pkg::QDR_KIND_PD) ? pd_byte :
                          (push_kind == qdr_pkg::QDR_KIND_HI) ? hi_byte : lo_byte;
   wire       push_go = push_valid && fifo_in_ready;
   wire [7:0] next_byte = fifo_out_valid ? fifo_out_data : `QDR_IDLE_BYTE;

   qdr_fifo2 #(.WIDTH(8), .DEPTH(2)) u_fifo (
      .clk       (CLK_SYS),
      .rst       (RST),
      .ce        (CE),
      .flush     (fifo_flush),
      .in_valid  (push_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (push_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out_data)
   );

   always_comb begin
      state_next    = state_reg;
      bit_cnt_next  = bit_cnt_reg;
      rx_shift_next = rx_shift_reg;
      ctrl_next     = ctrl_reg;
      tx_shift_next = tx_shift_reg;
      tx_cnt_next   = tx_cnt_reg;
      ack_next      = ack_reg;
      sda_oe_next   = sda_oe_reg;
      fifo_flush    = 1'b0;
      fifo_pop      = 1'b0;
      load_snap     = 1'b0;
      // a start or stop aborts whatever is in flight, even our own transmission
      if (start_det) begin
         state_next   = qdr_pkg::QDR_ADDR;
         bit_cnt_next = 4'h0;
         sda_oe_next  = 1'b0;
         fifo_flush   = 1'b1;
      end else if (stop_det) begin
         state_next  = qdr_pkg::QDR_IDLE;
         sda_oe_next = 1'b0;
         fifo_flush  = 1'b1;
      end else begin
         unique case (state_reg)
            qdr_pkg::QDR_IDLE, qdr_pkg::QDR_WAIT: begin
            end
            qdr_pkg::QDR_ADDR, qdr_pkg::QDR_CTRL: begin
               if (scl_rise && !byte_full) begin
                  rx_shift_next = {rx_shift_reg[6:0], sda_s};
                  bit_cnt_next  = bit_cnt_reg + 4'h1;
               end else if (scl_fall && byte_full) begin
                  bit_cnt_next = 4'h0;
                  if (state_reg == qdr_pkg::QDR_CTRL) begin
                     ctrl_next   = rx_shift_reg;
                     sda_oe_next = 1'b1;
                     state_next  = qdr_pkg::QDR_ACK_CTRL;
                  end else if (addr_match) begin
                     sda_oe_next = 1'b1;
                     state_next  = qdr_pkg::QDR_ACK_ADDR;
                     load_snap   = rw_read;
                  end else begin
                     state_next = qdr_pkg::QDR_IDLE;
                  end
               end
            end
            qdr_pkg::QDR_ACK_ADDR: begin
               if (scl_fall) begin
                  if (rw_read) begin
                     // take over sda with the first byte
                     fifo_pop      = 1'b1;
                     tx_shift_next = next_byte;
                     sda_oe_next   = !next_byte[7];
                     tx_cnt_next   = 2'h1;
                     state_next    = qdr_pkg::QDR_TX;
                  end else begin
                     sda_oe_next = 1'b0;
                     state_next  = qdr_pkg::QDR_CTRL;
                  end
               end
            end
            qdr_pkg::QDR_ACK_CTRL: begin
               // trailing write data is not part of this path and is ignored
               if (scl_fall) begin
                  sda_oe_next = 1'b0;
                  state_next  = qdr_pkg::QDR_WAIT;
               end
            end
            qdr_pkg::QDR_TX: begin
               if (scl_fall) begin
                  if (bit_cnt_reg[2:0] == `QDR_LAST_BIT) begin
                     sda_oe_next  = 1'b0;
                     bit_cnt_next = 4'h0;
                     ack_next     = 1'b0;
                     state_next   = qdr_pkg::QDR_MACK;
                  end else begin
                     tx_shift_next = {tx_shift_reg[6:0], 1'b1};
                     sda_oe_next   = !tx_shift_reg[6];
                     bit_cnt_next  = bit_cnt_reg + 4'h1;
                  end
               end
            end
            qdr_pkg::QDR_MACK: begin
               if (scl_rise) begin
                  ack_next = !sda_s;
               end else if (scl_fall) begin
                  if (ack_reg && (tx_cnt_reg < byte_total)) begin
                     fifo_pop      = 1'b1;
                     tx_shift_next = next_byte;
                     sda_oe_next   = !next_byte[7];
                     tx_cnt_next   = tx_cnt_reg + 2'h1;
                     state_next    = qdr_pkg::QDR_TX;
                  end else begin
                     // nack or surplus ack: bus stays released
                     state_next = qdr_pkg::QDR_DONE;
                  end
               end
            end
            qdr_pkg::QDR_DONE: begin
               sda_oe_next = 1'b0;                 // wait for restart or stop
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         scl_d_reg    <= 1'b1;
         sda_d_reg    <= 1'b1;
         state_reg    <= qdr_pkg::QDR_IDLE;
         bit_cnt_reg  <= 4'h0;
         rx_shift_reg <= 8'h00;
         ctrl_reg     <= 8'h00;
         tx_shift_reg <= 8'hff;
         tx_cnt_reg   <= 2'h0;
         ack_reg      <= 1'b0;
         sda_oe_reg   <= 1'b0;
      end else if (CE) begin
         scl_d_reg    <= scl_s;
         sda_d_reg    <= sda_s;
         state_reg    <= state_next;
         bit_cnt_reg  <= bit_cnt_next;
         rx_shift_reg <= rx_shift_next;
         ctrl_reg     <= ctrl_next;
         tx_shift_reg <= tx_shift_next;
         tx_cnt_reg   <= tx_cnt_next;
         ack_reg      <= ack_next;
         sda_oe_reg   <= sda_oe_next;
      end
   end

   // snapshot keeps a read coherent if software rewrites the channel mid-read
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         snap_reg     <= `QDR_CHAN_RESET;
         prod_idx_reg <= `QDR_PROD_IDLE;
      end else if (CE) begin
         if (load_snap) begin
            snap_reg     <= chan_mux;
            prod_idx_reg <= 2'h0;
         end else if (fifo_flush) begin
            prod_idx_reg <= `QDR_PROD_IDLE;
         end else if (push_go) begin
            prod_idx_reg <= prod_idx_reg + 2'h1;
         end
      end
   end

   // register port: four channel words, then a read-only status word
   wire chan_hit = (REG_ADDR <= `QDR_OFF_CHAN3) && (REG_ADDR[1:0] == 2'h0);
   wire stat_hit = (REG_ADDR == `QDR_OFF_STATUS);
   wire tx_active = (state_reg == qdr_pkg::QDR_TX) || (state_reg == qdr_pkg::QDR_MACK);
   wire [31:0] stat_word = {23'h000000, tx_active, ctrl_reg};
   wire [31:0] rd_mux = chan_hit ? {18'h00000, chan_reg[REG_ADDR[3:2]]} :
                        stat_hit ? stat_word : 32'h00000000;

   genvar g;
   for (g = 0; g < 4; g++) begin : g_chan
      wire chan_we = REG_WR && chan_hit && (REG_ADDR[3:2] == 2'(g));
      always_ff @(posedge CLK_SYS or posedge RST) begin
         if (RST) chan_reg[g] <= `QDR_CHAN_RESET;
         else if (CE && chan_we) chan_reg[g] <= REG_WDATA[13:0];
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) rdata_reg <= 32'h00000000;
      else if (CE) rdata_reg <= REG_RD ? rd_mux : 32'h00000000;
   end

   assign REG_RDATA = rdata_reg;
   assign SDA_O     = 1'b0;
   assign SDA_OE    = sda_oe_reg;

   // checks
   logic seen_wr_reg;
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) seen_wr_reg <= 1'b0;
      else if (CE && REG_WR) seen_wr_reg <= 1'b1;
   end

   sequence s_addr_acked;
      CE && !start_det && !stop_det && state_reg == qdr_pkg::QDR_ACK_ADDR && scl_fall && rw_read;
   endsequence
   sequence s_tx_first;
      state_reg == qdr_pkg::QDR_TX && tx_cnt_reg == 2'h1 && bit_cnt_reg == 4'h0;
   endsequence

   a_addr_ack_drive: assert property (@(posedge CLK_SYS) disable iff (RST)
      state_reg == qdr_pkg::QDR_ACK_ADDR |-> SDA_OE)
      else $error("address ack not driven low");
   a_ctrl_ack_drive: assert property (@(posedge CLK_SYS) disable iff (RST)
      (CE && state_reg == qdr_pkg::QDR_CTRL && scl_fall && byte_full && !start_det && !stop_det)
      |=> state_reg == qdr_pkg::QDR_ACK_CTRL && SDA_OE && ctrl_reg == $past(rx_shift_reg))
      else $error("control byte not taken and acked");
   a_read_takeover: assert property (@(posedge CLK_SYS) disable iff (RST)
      s_addr_acked |=> s_tx_first and (SDA_OE == !tx_shift_reg[7]))
      else $error("read phase did not start transmitting");
   a_chan_select: assert property (@(posedge CLK_SYS) disable iff (RST)
      (CE && load_snap) |=> snap_reg == $past(chan_mux))
      else $error("wrong channel captured");
   a_byte_limit: assert property (@(posedge CLK_SYS) disable iff (RST)
      tx_active |-> tx_cnt_reg <= (fmt_long ? 2'h3 : 2'h2))
      else $error("more bytes sent than the format allows");
   a_long_first_pd: assert property (@(posedge CLK_SYS) disable iff (RST)
      (s_addr_acked and fmt_long) |=> tx_shift_reg == {snap_reg[13:12], 6'h3f})
      else $error("long format did not begin with power-down byte");
   a_hi_byte_map: assert property (@(posedge CLK_SYS) disable iff (RST)
      (push_go && push_kind == qdr_pkg::QDR_KIND_HI) |-> push_data[7] == snap_reg[11]
      && push_data[0] == snap_reg[4])
      else $error("high byte misaligned");
   a_lo_byte_map: assert property (@(posedge CLK_SYS) disable iff (RST)
      (push_go && push_kind == qdr_pkg::QDR_KIND_LO) |-> push_data[7:4] == snap_reg[3:0])
      else $error("low byte misaligned");
   a_pd_byte_ones: assert property (@(posedge CLK_SYS) disable iff (RST)
      (push_go && push_kind == qdr_pkg::QDR_KIND_PD) |-> push_data[5:0] == 6'h3f
      && push_data[7:6] == snap_reg[13:12])
      else $error("power-down byte malformed");
   a_reset_clear: assert property (@(posedge CLK_SYS) disable iff (RST)
      !seen_wr_reg |-> chan_reg[0] == 14'h0 && chan_reg[1] == 14'h0
      && chan_reg[2] == 14'h0 && chan_reg[3] == 14'h0)
      else $error("channel register not cleared by reset");
   a_done_release: assert property (@(posedge CLK_SYS) disable iff (RST)
      state_reg == qdr_pkg::QDR_DONE |=> !SDA_OE)
      else $error("bus held after read ended");
endmodule
`default_nettype wire

// ==== verif/qdr_i2c_master.sv ====
// behavioural i2c bus master that reads channel data back from the converter slave
// assumes the bench resolves sda as open drain with a pull-up, and clk runs at 50 MHz
`timescale 1ns/100ps
`default_nettype none
module qdr_i2c_master (
   input  wire logic clk,    // system clock, paces the bit timing
   output var  logic scl,    // i2c clock, stands high between frames
   output var  logic sda_oe, // high while pulling sda low
   input  wire logic sda     // resolved sda level
);
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask
   // start and repeated start alike; scl drops first so a slave ack is ended cleanly
   task automatic start();
      scl <= 1'b0;
      wait_clk(2);
      sda_oe <= 1'b0;
      wait_clk(2);
      scl <= 1'b1;
      wait_clk(4);
      sda_oe <= 1'b1;
      wait_clk(4);
   endtask
   task automatic stop();
      scl <= 1'b0;
      wait_clk(2);
      sda_oe <= 1'b1;
      wait_clk(2);
      scl <= 1'b1;
      wait_clk(4);
      sda_oe <= 1'b0;
      wait_clk(4);
   endtask
   // data moves two cycles after scl falls, so it never races the fall in the synchronisers
   task automatic xfer_bit(input logic b, output logic s);
      scl <= 1'b0;
      wait_clk(2);
      sda_oe <= !b;
      wait_clk(2);
      scl <= 1'b1;
      wait_clk(4);
      s = sda;
   endtask
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) xfer_bit(d[i], s);
      xfer_bit(1'b1, s);
      ack = !s;
   endtask
   task automatic recv_byte(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(1'b1, s);
         d[i] = s;
      end
      xfer_bit(!ack, s);
   endtask
   // full readback; n bytes read, every one acked but the last
   task automatic readback(input logic [6:0] addr, input logic [7:0] ctrl, input int n,
                           input logic use_rs, output logic [2:0] acks, output logic [23:0] data);
      logic [7:0] b;
      data = 24'h000000;
      start();
      send_byte({addr, 1'b0}, acks[0]);
      send_byte(ctrl, acks[1]);
      start();
      send_byte({addr, 1'b1}, acks[2]);
      for (int i = 0; i < n; i++) begin
         recv_byte(i < n - 1, b);
         data = {data[15:0], b};
      end
      if (use_rs) begin
         start();
      end else begin
         stop();
      end
   endtask
endmodule
`default_nettype wire

// ==== verif/qdr_readback_tb_top.sv ====
// self-checking bench for the readback slave: register port plus i2c master model
// assumes the straps give address 1001110 and that the design never stretches scl
`timescale 1ns/100ps
`default_nettype none
module qdr_readback_tb_top;
   localparam logic [6:0] DEV_ADDR = 7'h4e;
   logic        clk_sys;
   logic        rst;
   logic        reg_wr;
   logic        reg_rd;
   logic        scl;
   logic        sda_m_oe;
   logic        sda_oe;
   wire  logic  sda;
   logic [4:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic [31:0] rd;
   logic [2:0]  acks;
   logic [23:0] data;
   int          num_errors;
   int          cmp_count;
   int          cycles;
   logic [13:0] chan_val [4] = '{14'h0abc, 14'h1123, 14'h2fed, 14'h3456};
   // open drain with pull-up: low whenever either party pulls
   assign sda = !(sda_m_oe || sda_oe);
   qdr_readback qdr_readback_i (
      .CLK_SYS(clk_sys), .RST(rst), .CE(1'b1), .SCL_I(scl), .SDA_I(sda), .SDA_O(),
      .SDA_OE(sda_oe), .ADDR_PIN_HI(1'b1), .ADDR_PIN_LO(1'b0), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));
   qdr_i2c_master qdr_i2c_master_i (.clk(clk_sys), .scl(scl), .sda_oe(sda_m_oe), .sda(sda));
   always #10 clk_sys = ~clk_sys;
   task automatic print_verdict();
      if (num_errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         print_verdict();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic reg_write(input logic [4:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic reg_read(input logic [4:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
      d = reg_rdata;
      @(posedge clk_sys);
   endtask
   task automatic test_reset();
      for (int a = 0; a < 5; a++) begin
         reg_read(5'(a * 4), rd);
         check(rd, 32'h00000000);
      end
      qdr_i2c_master_i.readback(DEV_ADDR, 8'h00, 2, 1'b0, acks, data);
      check({8'h00, data}, 32'h00000000);
   endtask
   // upper bits beyond the fourteen stored ones must not stick
   task automatic test_width();
      reg_write(5'h00, 32'hffffffff);
      reg_read(5'h00, rd);
      check(rd, 32'h00003fff);
      reg_read(5'h14, rd);
      check(rd, 32'h00000000);
      for (int c = 0; c < 4; c++) reg_write(5'(c * 4), {18'h0, chan_val[c]});
   endtask
   task automatic test_readback();
      logic [13:0] v;
      logic [23:0] exp;
      for (int c = 0; c < 4; c++) begin
         for (int f = 0; f < 2; f++) begin
            v = chan_val[c];
            exp = {(f == 1) ? {v[13:12], 6'h3f} : 8'h00, v[11:4], v[3:0], 4'h0};
            qdr_i2c_master_i.readback(DEV_ADDR, {5'b00010, 2'(c), 1'(f)}, 2 + f, 1'(f),
                                      acks, data);
            check({29'h0, acks}, 32'h00000007);
            check({8'h00, data}, {8'h00, exp});
         end
      end
      reg_read(5'h10, rd);
      check(rd, 32'h00000017);
   endtask
   // master acks the low byte, so the slave must let sda float for the extra byte
   task automatic test_extra_ack();
      qdr_i2c_master_i.readback(DEV_ADDR, 8'h02, 3, 1'b0, acks, data);
      check({8'h00, data}, {8'h00, chan_val[1][11:4], chan_val[1][3:0], 4'h0, 8'hff});
   endtask
   task automatic test_foreign();
      qdr_i2c_master_i.readback(7'h4f, 8'h00, 2, 1'b0, acks, data);
      check({29'h0, acks}, 32'h00000000);
      check({8'h00, data}, 32'h0000ffff);
   endtask
   initial begin
      clk_sys = 1'b0;
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 5'h00;
      reg_wdata = 32'h00000000;
      num_errors = 0;
      cmp_count = 0;
      cycles = 0;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      test_reset();
      test_width();
      test_readback();
      test_extra_ack();
      test_foreign();
      print_verdict();
   end
endmodule
`default_nettype wire
